// >>> logic/tpm_top.sv
/*
  Channel transmit input with two roles: telecom-bus payload indicator or
  HDLC send-message command, plus byte capture and a flag/data byte stream.
  Assumes bus clock, HDLC clock and pins are asynchronous to sys_clk_in and
  at least several times slower; their edges are found by 3-stage sampling.
  Limitation: each clock level must last two sys_clk_in cycles or more,
  otherwise an edge is lost in the samplers and its byte is never seen.
*/
// Notes on behaviour
// RULE1: Bus enabled selects payload indicator role, otherwise HDLC send-message role.
// RULE2: Source drives indicator low during overhead bytes, high otherwise.
// RULE3: Payload indicator is sampled on the falling edge of bus clock.
// RULE4: Send-message role applies only when framer is in high-speed HDLC mode.
// RULE5: Outside HDLC mode with bus disabled, the pin is tied low externally.
// RULE6: Command high latches the HDLC data byte on each HDLC clock rising edge.
// RULE7: Every latched byte is passed on for framing into DS3/E3 payload; code drops a byte latched while the 4-entry FIFO is full.
// RULE8: Command low latches nothing and emits continuous 0x7E flag octets; code first sends bytes left in the FIFO, then one flag per octet_req_in.
`timescale 1ns/1ps
module tpm_top (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic bus_enable_in,
  input wire logic hdlc_mode_in,
  input wire logic shared_pin_in,
  input wire logic tx_bus_clock_in,
  input wire logic [7:0] tx_bus_data_in,
  input wire logic hdlc_tx_clock_in,
  input wire logic [7:0] hdlc_tx_byte_port_in,
  input wire logic octet_req_in,
  output logic tx_bus_payload_indicator_out,
  output logic [7:0] tx_bus_data_out,
  output logic tx_bus_sample_out,
  output logic [7:0] hdlc_octet_out,
  output logic hdlc_octet_valid_out,
  output logic hdlc_octet_is_flag_out,
  output logic hdlc_overrun_out
);
  localparam int N = tpm_pkg::SYNC_STAGES;

  typedef struct packed {
    // Three-stage samplers of the asynchronous inputs
    logic [N-1:0] pin_s;
    logic [N-1:0] bck_s;
    logic [N-1:0] hck_s;
    logic [N-1:0][7:0] bdat_s;
    logic [N-1:0][7:0] hdat_s;
    // Filtered levels, changed only when stages two and three agree
    logic pin_f;
    logic bck_f;
    logic hck_f;
    // Last bus sample
    logic pl_ind;
    logic [7:0] bus_byte;
    logic bus_smp;
    // HDLC capture and octet stream
    logic [7:0] cap_byte;
    logic cap_vld;
    logic [7:0] oct;
    logic oct_vld;
    logic oct_flag;
    logic ovr;
  } tpm_st_t;

  tpm_st_t s_q, s_d;
  tpm_pkg::tpm_role_t role;
  logic send_cmd;
  logic bck_fall, hck_rise;
  logic pin_agree, bck_agree, hck_agree;
  logic bus_take, hdlc_take, ovr_clear;
  logic f_wready, f_rvalid, f_rready;
  logic [7:0] f_rdata;

  // ------------------------------------------------------------
  // Role selection
  // ------------------------------------------------------------
  always_comb begin
    role = tpm_pkg::TPM_ROLE_OFF;
    unique case ({bus_enable_in, hdlc_mode_in})
      2'b10, 2'b11: begin
        role = tpm_pkg::TPM_ROLE_PAYLOAD; // [RULE1]
      end
      2'b01: begin
        role = tpm_pkg::TPM_ROLE_HDLC; // [RULE4]
      end
      2'b00: begin
        // Pin expected grounded here; it is ignored regardless [RULE5]
        role = tpm_pkg::TPM_ROLE_OFF;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Sampled inputs and edge detection
  // ------------------------------------------------------------
  // Edges and levels count only once stages two and three agree
  assign pin_agree = (s_q.pin_s[1] == s_q.pin_s[2]);
  assign bck_agree = (s_q.bck_s[1] == s_q.bck_s[2]);
  assign hck_agree = (s_q.hck_s[1] == s_q.hck_s[2]);
  assign bck_fall = s_q.bck_f && bck_agree && !s_q.bck_s[2];
  assign hck_rise = !s_q.hck_f && hck_agree && s_q.hck_s[2];
  assign send_cmd = (role == tpm_pkg::TPM_ROLE_HDLC) && s_q.pin_f;
  assign f_rready = octet_req_in;

  // ------------------------------------------------------------
  // Per-role strobes
  // ------------------------------------------------------------
  // Samplers keep running in every role; only these strobes are gated
  always_comb begin
    bus_take = 1'b0;
    hdlc_take = 1'b0;
    ovr_clear = 1'b1;
    unique case (role)
      tpm_pkg::TPM_ROLE_PAYLOAD: begin
        bus_take = bck_fall; // [RULE3]
      end
      tpm_pkg::TPM_ROLE_HDLC: begin
        hdlc_take = send_cmd && hck_rise; // [RULE6]
        ovr_clear = 1'b0;
      end
      tpm_pkg::TPM_ROLE_OFF: begin
        // The pin is not looked at in this role
      end
      default: begin
        bus_take = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Capture FIFO between HDLC data port and the octet stream
  // ------------------------------------------------------------
  tpm_fifo #(
    .WIDTH(tpm_pkg::BYTE_W),
    .DEPTH(tpm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wr_data_in(s_q.cap_byte),
    .wr_valid_in(s_q.cap_vld),
    .wr_ready_out(f_wready),
    .rd_data_out(f_rdata),
    .rd_valid_out(f_rvalid),
    .rd_ready_in(f_rready)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pin_s = {s_q.pin_s[N-2:0], shared_pin_in};
    s_d.bck_s = {s_q.bck_s[N-2:0], tx_bus_clock_in};
    s_d.hck_s = {s_q.hck_s[N-2:0], hdlc_tx_clock_in};
    s_d.bdat_s = {s_q.bdat_s[N-2:0], tx_bus_data_in};
    s_d.hdat_s = {s_q.hdat_s[N-2:0], hdlc_tx_byte_port_in};
    if (pin_agree) begin
      s_d.pin_f = s_q.pin_s[2];
    end
    if (bck_agree) begin
      s_d.bck_f = s_q.bck_s[2];
    end
    if (hck_agree) begin
      s_d.hck_f = s_q.hck_s[2];
    end
    s_d.bus_smp = 1'b0;
    s_d.cap_vld = 1'b0;
    s_d.oct_vld = 1'b0;

    // Indicator low marks an overhead byte, high a payload byte [RULE2]
    if (bus_take) begin
      s_d.pl_ind = s_q.pin_f; // [RULE3]
      s_d.bus_byte = s_q.bdat_s[2];
      s_d.bus_smp = 1'b1;
    end

    // A byte offered while the FIFO is full is dropped and flagged
    if (hdlc_take) begin
      s_d.cap_byte = s_q.hdat_s[2]; // [RULE6]
      s_d.cap_vld = 1'b1;
      if (!f_wready) begin
        s_d.ovr = 1'b1;
      end
    end
    if (ovr_clear) begin
      s_d.ovr = 1'b0;
    end

    if (octet_req_in) begin
      s_d.oct_vld = 1'b1;
      if (f_rvalid) begin
        s_d.oct = f_rdata; // [RULE7]
        s_d.oct_flag = 1'b0;
      end else begin
        // No captured data pending: idle fill is flags [RULE8]
        s_d.oct = tpm_pkg::FLAG_OCTET;
        s_d.oct_flag = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      s_q.pl_ind <= 1'b1;
      s_q.oct <= tpm_pkg::FLAG_OCTET;
      s_q.oct_flag <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign tx_bus_payload_indicator_out = s_q.pl_ind;
  assign tx_bus_data_out = s_q.bus_byte;
  assign tx_bus_sample_out = s_q.bus_smp;
  assign hdlc_octet_out = s_q.oct;
  assign hdlc_octet_valid_out = s_q.oct_vld;
  assign hdlc_octet_is_flag_out = s_q.oct_flag;
  assign hdlc_overrun_out = s_q.ovr;
endmodule

// >>> shared/tpm_pkg.sv
/*
  Package for the transmit payload-indicator / HDLC send-message block.
  Holds widths, flag value, synchroniser depth and state encodings.
  Assumes nothing of its surroundings.
*/
package tpm_pkg;
  localparam int BYTE_W = 8;
  localparam logic [7:0] FLAG_OCTET = 8'h7E;
  localparam int SYNC_STAGES = 3;
  localparam int FIFO_DEPTH = 4;
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  typedef enum logic [2:0] {
    TPM_ROLE_OFF = 3'b001,
    TPM_ROLE_PAYLOAD = 3'b010,
    TPM_ROLE_HDLC = 3'b100
  } tpm_role_t;
  typedef enum logic [1:0] {
    TPM_TX_FLAG = 2'b01,
    TPM_TX_DATA = 2'b10
  } tpm_tx_t;
endpackage

// >>> logic/tpm_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module tpm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tpm_fifo_st_t;
  tpm_fifo_st_t s_q, s_d;
  logic push, pop;

  assign wr_ready_out = (s_q.cnt != (AW+1)'(DEPTH));
  assign rd_valid_out = (s_q.cnt != '0);
  assign rd_data_out = s_q.mem[s_q.rp];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = wr_data_in;
      s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// >>> dv/tpm_top_checker.sv
/* Checker for tpm_top port timing.
   Assumes the sync reset and clock of tpm_top. */
`timescale 1ns/1ps
module tpm_top_checker (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic bus_enable_in,
  input wire logic hdlc_mode_in,
  input wire logic tx_bus_clock_in,
  input wire logic octet_req_in,
  input wire logic tx_bus_payload_indicator_out,
  input wire logic tx_bus_sample_out,
  input wire logic [7:0] hdlc_octet_out,
  input wire logic hdlc_octet_valid_out,
  input wire logic hdlc_octet_is_flag_out,
  input wire logic hdlc_overrun_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  sample_pulse_a: assert property (tx_bus_sample_out |=> !tx_bus_sample_out)
    else $error("long sample");
  sample_fall_a: assert property (tx_bus_sample_out |-> !$past(tx_bus_clock_in, 2))
    else $error("sample off fall");
  role_bus_a: assert property (tx_bus_sample_out |-> $past(bus_enable_in))
    else $error("sample bus off");
  indic_hold_a: assert property ($changed(tx_bus_payload_indicator_out) |-> tx_bus_sample_out)
    else $error("indicator moved");
  valid_req_a: assert property (octet_req_in |=> hdlc_octet_valid_out)
    else $error("octet missing");
  valid_only_a: assert property (!octet_req_in |=> !hdlc_octet_valid_out)
    else $error("stray octet");
  flag_value_a: assert property (hdlc_octet_is_flag_out |-> hdlc_octet_out == 8'h7E)
    else $error("bad flag");
  overrun_clr_a: assert property ((bus_enable_in || !hdlc_mode_in) [*2] |=> !hdlc_overrun_out)
    else $error("overrun kept");
endmodule
bind tpm_top tpm_top_checker u_chk (.sys_clk_in, .resetn_in, .bus_enable_in, .hdlc_mode_in,
  .tx_bus_clock_in, .octet_req_in, .tx_bus_payload_indicator_out, .tx_bus_sample_out,
  .hdlc_octet_out, .hdlc_octet_valid_out, .hdlc_octet_is_flag_out, .hdlc_overrun_out);

// >>> dv/tpm_src.sv
/* Far-side source of bus and HDLC traffic.
   Clocks stand still between bursts; released data shows its inverse. */
`timescale 1ns/1ps
module tpm_src (
  output logic bus_clk_out = 1'b0,
  output logic hdlc_clk_out = 1'b0,
  output logic pin_out = 1'b0,
  output logic [7:0] data_out = 8'h00,
  output logic [7:0] hdlc_data_out = 8'h00
);
  task automatic bus_burst(input logic pl, input logic [7:0] d);
    pin_out = pl;
    data_out = d;
    #50 bus_clk_out = 1'b1;
    #50 bus_clk_out = 1'b0;
    #50 data_out = ~d;
  endtask
  task automatic hdlc_burst(input logic cmd, input logic [7:0] d, input int n);
    pin_out = cmd;
    for (int i = 0; i < n; i++) begin
      hdlc_data_out = d + 8'(i);
      #50 hdlc_clk_out = 1'b1;
      #50 hdlc_clk_out = 1'b0;
    end
    hdlc_data_out = ~hdlc_data_out;
  endtask
endmodule

// >>> dv/tpm_top_test.sv
/* Bench for tpm_top: bus sampling, HDLC capture, flag fill.
   Assumes tpm_src as the far side. */
`timescale 1ns/1ps
module tpm_top_test;
  logic clk = 0, rst_n = 0, ben = 0, hm = 0, req = 0, bclk, hclk, pin, ind, smp, vld, flg, ovr;
  logic exp_pl;
  logic [7:0] bd, hd, bdo, oct, exp_d, eo;
  logic [31:0] rnd = 32'h61EED496;
  logic [7:0] q[$];
  int failures = 0, n_tests = 0, n_smp = 0, k;
  always #5 clk = ~clk;
  tpm_src src (.bus_clk_out(bclk), .hdlc_clk_out(hclk), .pin_out(pin), .data_out(bd),
    .hdlc_data_out(hd));
  tpm_top DUT (.sys_clk_in(clk), .resetn_in(rst_n), .bus_enable_in(ben), .hdlc_mode_in(hm),
    .shared_pin_in(pin), .tx_bus_clock_in(bclk), .tx_bus_data_in(bd), .hdlc_tx_clock_in(hclk),
    .hdlc_tx_byte_port_in(hd), .octet_req_in(req), .tx_bus_payload_indicator_out(ind),
    .tx_bus_data_out(bdo), .tx_bus_sample_out(smp), .hdlc_octet_out(oct),
    .hdlc_octet_valid_out(vld), .hdlc_octet_is_flag_out(flg), .hdlc_overrun_out(ovr));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input bit ok);
    n_tests++;
    if (!ok) begin
      failures++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic get_octet();
    logic f;
    f = (q.size() == 0);
    eo = f ? tpm_pkg::FLAG_OCTET : q.pop_front();
    @(negedge clk) req = 1;
    @(negedge clk) chk(vld === 1'b1 && oct === eo && flg === f);
    req = 0;
  endtask
  // Expected FIFO content: bytes beyond its depth are lost
  task automatic hburst(input logic c, input int n, input bit take);
    rnd = lfsr(rnd);
    for (int i = 0; i < n; i++)
      if (take && q.size() < 4) q.push_back(rnd[7:0] + 8'(i));
    src.hdlc_burst(c, rnd[7:0], n);
    repeat (8) @(negedge clk);
  endtask
  always @(negedge bclk) begin
    exp_pl = pin;
    exp_d = bd;
  end
  always @(negedge clk) if (smp === 1'b1) begin
    n_smp++;
    chk(ind === exp_pl && bdo === exp_d);
  end
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    ben = 1;
    for (k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      src.bus_burst(rnd[8] & (k != 0), rnd[7:0]);
      repeat (4) @(negedge clk);
    end
    ben = 0;
    src.bus_burst(1'b0, 8'hA5);
    repeat (6) @(negedge clk);
    chk(n_smp == 8);
    $display("test bus done");
    hm = 1;
    for (k = 2; k < 5; k++) begin
      hburst(1'b1, k, 1'b1);
      repeat (k + 1) get_octet();
    end
    hburst(1'b1, 6, 1'b1);
    chk(ovr === 1'b1);
    repeat (5) get_octet();
    ben = 1;
    repeat (3) @(negedge clk);
    chk(ovr === 1'b0);
    ben = 0;
    hburst(1'b0, 4, 1'b0);
    repeat (2) get_octet();
    hm = 0;
    hburst(1'b0, 2, 1'b0);
    get_octet();
    hm = 1;
    ben = 1;
    hburst(1'b1, 3, 1'b0);
    get_octet();
    chk(n_smp == 8);
    $display("test hdlc done");
    end_sim();
  end
endmodule
